/* File: ousr_pkg.sv */
// package: constants and register map of the octal universal shift register
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package ousr_pkg;
   localparam int          WIDTH       = 8;
   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATE  = 32'h0000_0004;
   localparam logic [31:0] ADDR_FIFO   = 32'h0000_0008;
   localparam logic [31:0] ADDR_STAT   = 32'h0000_000c;
   localparam int          CTRL_MODE_LO = 0;
   localparam int          CTRL_MODE_HI = 1;
   localparam int          CTRL_CLR_N   = 2;
   localparam int          CTRL_OEA_N   = 3;
   localparam int          CTRL_OEB_N   = 4;
   localparam int          CTRL_RSI     = 5;
   localparam int          CTRL_LSI     = 6;
   localparam int          CTRL_STEP    = 7;
   localparam logic [7:0]  CTRL_RESET   = 8'h1c;
   localparam logic [31:0] BAD_READ     = 32'hdead_0bad;
   localparam int          FIFO_DEPTH   = 4;
   typedef enum logic [1:0] {OUSR_HOLD, OUSR_RIGHT, OUSR_LEFT, OUSR_LOAD} ousr_mode_t;
endpackage

/* File: ousr_fifo.sv */
// module: small valid/ready FIFO for the parallel data path
module ousr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
         $error("fifo depth must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign inReady  = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem[rdPtr_r];
   assign push     = ce && inValid && inReady;
   assign pop      = ce && outValid && outReady;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_r] <= inData;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wrPtr_r <= wrPtr_r + 1'b1;
         if (pop)
            rdPtr_r <= rdPtr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule

/* File: ousr_sync.sv */
// module: three-stage synchroniser, change accepted when stages two and three agree
module ousr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] out_r;
   initial
   begin
      if (WIDTH < 1)
         $error("sync width must be positive");
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         out_r <= '0;
      end
      else if (ce)
      begin
         s1_r <= async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_r[i] == s3_r[i])
               out_r[i] <= s3_r[i];
         end
      end
   end
   assign synced = out_r;
endmodule

/* File: ousr_top.sv */
// module: octal universal shift register with APB control
module ousr_top #(
   parameter int WIDTH = ousr_pkg::WIDTH,
   parameter int DEPTH = ousr_pkg::FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [WIDTH-1:0] parallelIn,
   output logic      [WIDTH-1:0] parallelOut,
   output logic      [WIDTH-1:0] parallelOe,
   output logic                  firstStageSerialOut,
   output logic                  lastStageSerialOut,
   output logic                  loadReady
);
   initial
   begin
      if (WIDTH != 8)
         $error("register width must be 8");
   end

   //-------------------------------------------------------------------------
   // control register and apb slave
   //-------------------------------------------------------------------------
   logic [7:0]       ctrl_r;
   logic [WIDTH-1:0] stage_r;
   logic [WIDTH-1:0] stage_nxt;
   logic             step_r;
   logic             apbAccess;
   logic             fifoValid;
   logic [WIDTH-1:0] fifoData;
   logic             fifoPop;
   logic [WIDTH-1:0] pinSync;
   logic             fifoInReady;
   logic             clearActive;
   logic             busEnable;
   logic             modeLo;
   logic             modeHi;
   logic             ctrlWrite;

   assign apbAccess   = psel && penable && ce;
   assign modeLo      = ctrl_r[ousr_pkg::CTRL_MODE_LO];
   assign modeHi      = ctrl_r[ousr_pkg::CTRL_MODE_HI];
   assign clearActive = !ctrl_r[ousr_pkg::CTRL_CLR_N];
   // writes land at the access edge, the one at which the master sees ready
   assign ctrlWrite   = apbAccess && pready && pwrite && paddr == ousr_pkg::ADDR_CTRL;

   function automatic ousr_pkg::ousr_mode_t decodeMode(input logic hi, input logic lo);
      ousr_pkg::ousr_mode_t m;
      m = ousr_pkg::OUSR_HOLD;
      if (hi && lo)
         m = ousr_pkg::OUSR_LOAD;
      else if (lo)
         m = ousr_pkg::OUSR_RIGHT;
      else if (hi)
         m = ousr_pkg::OUSR_LEFT;
      return m;
   endfunction

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl_r <= ousr_pkg::CTRL_RESET;
      else if (ctrlWrite)
         ctrl_r <= pwdata[7:0];
   end

   // step request is a one-shot clock-edge event for the register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         step_r <= 1'b0;
      else if (ce)
         step_r <= ctrlWrite && pwdata[ousr_pkg::CTRL_STEP];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else if (ce)
      begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            if (paddr == ousr_pkg::ADDR_CTRL)
               prdata <= {24'h00_0000, ctrl_r & 8'h7f};
            else if (paddr == ousr_pkg::ADDR_STATE)
               prdata <= {24'h00_0000, stage_r};
            else if (paddr == ousr_pkg::ADDR_FIFO)
               prdata <= {23'h00_0000, fifoValid, fifoData};
            else if (paddr == ousr_pkg::ADDR_STAT)
               prdata <= {26'h000_0000, fifoInReady, fifoValid, busEnable,
                          modeHi, modeLo, clearActive};
            else
            begin
               prdata  <= ousr_pkg::BAD_READ;
               pslverr <= 1'b1;
            end
         end
      end
   end

   //-------------------------------------------------------------------------
   // parallel pin capture through synchroniser and fifo
   //-------------------------------------------------------------------------
   ousr_sync #(.WIDTH(WIDTH)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .async   (parallelIn),
      .synced  (pinSync)
   );

   // a load step consumes one captured word; the fifo fills while the pins are released
   assign fifoPop = step_r && !clearActive && decodeMode(modeHi, modeLo) == ousr_pkg::OUSR_LOAD;

   ousr_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .inValid  (!busEnable),
      .inReady  (fifoInReady),
      .inData   (pinSync),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   //-------------------------------------------------------------------------
   // shift register core
   //-------------------------------------------------------------------------
   always_comb
   begin
      stage_nxt = stage_r;
      case (decodeMode(modeHi, modeLo))
         ousr_pkg::OUSR_LOAD:
            if (fifoValid)
               stage_nxt = fifoData;
         ousr_pkg::OUSR_RIGHT:
            stage_nxt = {stage_r[WIDTH-2:0], ctrl_r[ousr_pkg::CTRL_RSI]};
         ousr_pkg::OUSR_LEFT:
            stage_nxt = {ctrl_r[ousr_pkg::CTRL_LSI], stage_r[WIDTH-1:1]};
         default:
            stage_nxt = stage_r;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || (ce && clearActive))
         stage_r <= '0;
      else if (ce && step_r)
         stage_r <= stage_nxt;
   end

   //-------------------------------------------------------------------------
   // pin drivers
   //-------------------------------------------------------------------------
   assign busEnable = !ctrl_r[ousr_pkg::CTRL_OEA_N] && !ctrl_r[ousr_pkg::CTRL_OEB_N]
                      && !(modeHi && modeLo);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         parallelOut         <= '0;
         parallelOe          <= '0;
         firstStageSerialOut <= 1'b0;
         lastStageSerialOut  <= 1'b0;
         loadReady           <= 1'b0;
      end
      else if (ce)
      begin
         parallelOut         <= stage_r;
         parallelOe          <= {WIDTH{busEnable}};
         firstStageSerialOut <= stage_r[0];
         lastStageSerialOut  <= stage_r[WIDTH-1];
         loadReady           <= fifoInReady;
      end
   end

   //-------------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------------
   sequence stepSeq;
      ce && step_r && !clearActive;
   endsequence

   clear_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && clearActive |=> stage_r == '0)
      else $error("clear did not zero the stages");

   load_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      stepSeq and (modeHi && modeLo && fifoValid) |=> stage_r == $past(fifoData))
      else $error("load did not take pin data");

   shift_right_a: assert property (@(posedge clk) disable iff (sys_rst)
      stepSeq and (!modeHi && modeLo)
      |=> stage_r == {$past(stage_r[6:0]), $past(ctrl_r[ousr_pkg::CTRL_RSI])})
      else $error("right shift wrong");

   shift_left_a: assert property (@(posedge clk) disable iff (sys_rst)
      stepSeq and (modeHi && !modeLo)
      |=> stage_r == {$past(ctrl_r[ousr_pkg::CTRL_LSI]), $past(stage_r[7:1])})
      else $error("left shift wrong");

   hold_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !clearActive && !modeHi && !modeLo |=> $stable(stage_r))
      else $error("hold changed the stages");

   pin_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce ##1 ce |-> parallelOut == $past(stage_r))
      else $error("pins do not show stages");

   oe_release_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && (ctrl_r[ousr_pkg::CTRL_OEA_N] || ctrl_r[ousr_pkg::CTRL_OEB_N]) |=> parallelOe == '0)
      else $error("pins driven while disabled");

   load_release_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && modeHi && modeLo |=> parallelOe == '0)
      else $error("pins driven during load mode");

   serial_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce ##1 ce |-> firstStageSerialOut == $past(stage_r[0])
                   && lastStageSerialOut == $past(stage_r[7]))
      else $error("serial outputs wrong");

   released_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
      stepSeq and (!busEnable && !modeHi && modeLo)
      |=> stage_r[0] == $past(ctrl_r[ousr_pkg::CTRL_RSI]))
      else $error("no shift while pins released");

   clear_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && clearActive && step_r |=> stage_r == '0)
      else $error("step beat the clear");

   drive_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !ctrl_r[ousr_pkg::CTRL_OEA_N] && !ctrl_r[ousr_pkg::CTRL_OEB_N]
      && !(modeHi && modeLo) |=> parallelOe == '1)
      else $error("pins not driven while enabled");

   load_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> loadReady == $past(fifoInReady))
      else $error("load ready does not follow the fifo");

   fifo_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !busEnable && fifoInReady |=> fifoValid)
      else $error("released pins not captured");

   //-------------------------------------------------------------------------
   // checks: clock enable
   //-------------------------------------------------------------------------
   freeze_state_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ce |=> $stable(stage_r) && $stable(ctrl_r) && $stable(step_r))
      else $error("state moved while clock enable low");

   freeze_pins_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ce |=> $stable(parallelOut) && $stable(parallelOe) && $stable(pready))
      else $error("outputs moved while clock enable low");

   //-------------------------------------------------------------------------
   // checks: apb slave
   //-------------------------------------------------------------------------
   // setup phase as the slave takes it
   sequence setupSeq;
      ce && psel && !penable;
   endsequence

   // setup of a control write followed by its access phase
   sequence ctrlWriteSeq;
      ce && psel && !penable && pwrite && paddr == ousr_pkg::ADDR_CTRL
      ##1 ce && psel && penable;
   endsequence

   ready_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq |=> pready)
      else $error("no ready after setup");

   ready_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && pready |=> !pready)
      else $error("ready held past access");

   error_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
      pslverr |-> pready)
      else $error("error without ready");

   unmapped_error_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (paddr > ousr_pkg::ADDR_STAT)
      |=> pslverr && prdata == ousr_pkg::BAD_READ)
      else $error("unmapped access not refused");

   mapped_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (paddr <= ousr_pkg::ADDR_STAT && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped access refused");

   state_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (!pwrite && paddr == ousr_pkg::ADDR_STATE)
      |=> prdata == {24'h00_0000, $past(stage_r)})
      else $error("state read wrong");

   ctrl_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (!pwrite && paddr == ousr_pkg::ADDR_CTRL)
      |=> prdata[7] == 1'b0 && prdata[6:0] == $past(ctrl_r[6:0]))
      else $error("control read wrong");

   stat_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (!pwrite && paddr == ousr_pkg::ADDR_STAT)
      |=> prdata[0] == $past(clearActive) && prdata[2:1] == $past(ctrl_r[1:0]))
      else $error("status read wrong");

   fifo_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      setupSeq and (!pwrite && paddr == ousr_pkg::ADDR_FIFO)
      |=> prdata[8] == $past(fifoValid))
      else $error("fifo read wrong");

   ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctrlWriteSeq |=> ctrl_r == $past(pwdata[7:0]))
      else $error("control write lost");

   step_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      ce && step_r |=> !step_r)
      else $error("step longer than one edge");
endmodule

/* File: ousr_bus_model.sv */
// shared parallel bus model facing the register's three-state pins
module ousr_bus_model (
   input  wire logic [7:0] parallelOut,
   input  wire logic [7:0] parallelOe,
   input  wire logic [7:0] busData,
   output logic      [7:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ps;

   //------------------------------------------------------------
   // wire resolution
   //------------------------------------------------------------
   // the bus only drives pins that the register has released
   assign pinLevel = (parallelOe & parallelOut) | (~parallelOe & busData);
endmodule

/* File: tb_top.sv */
// self-checking bench of the octal universal shift register
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, sysRst, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, rdData;
   logic        pready, pslverr, firstOut, lastOut, loadReady, rdErr;
   logic        ceIn;
   logic [7:0]  parOut, parOe, pins, busData, expState;
   int          errors, testsRun, cycles;

   ousr_top dut (
      .clk                 (clk),
      .sys_rst             (sysRst),
      .ce                  (ceIn),
      .psel                (psel),
      .penable             (penable),
      .pwrite              (pwrite),
      .paddr               (paddr),
      .pwdata              (pwdata),
      .prdata              (prdata),
      .pready              (pready),
      .pslverr             (pslverr),
      .parallelIn          (pins),
      .parallelOut         (parOut),
      .parallelOe          (parOe),
      .firstStageSerialOut (firstOut),
      .lastStageSerialOut  (lastOut),
      .loadReady           (loadReady)
   );

   ousr_bus_model bus (
      .parallelOut (parOut),
      .parallelOe  (parOe),
      .busData     (busData),
      .pinLevel    (pins)
   );

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   task automatic results();
      if (errors == 0 && testsRun > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer, then an idle cycle so the next setup never collides
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      if (pready !== 1'b1)
         chk("pready", 32'h1, 32'h0);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask

   task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(name, exp, rdData);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] mode,
                                       input logic clrN, oeaN, oebN, rsi, lsi, stp);
      return {24'h0, stp, lsi, rsi, oebN, oeaN, clrN, mode};
   endfunction

   // one clock step with pins released, then state and serial outputs judged
   task automatic step(input logic [1:0] mode, input logic rsi, input logic lsi);
      wr(ousr_pkg::ADDR_CTRL, ctl(mode, 1'b1, 1'b1, 1'b1, rsi, lsi, 1'b1));
      case (mode)
         2'b01: expState = {expState[6:0], rsi};
         2'b10: expState = {lsi, expState[7:1]};
         default: ;
      endcase
      rd("state", ousr_pkg::ADDR_STATE, {24'h0, expState});
      chk("first", {31'h0, expState[0]}, {31'h0, firstOut});
      chk("last", {31'h0, expState[7]}, {31'h0, lastOut});
   endtask

   //------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------
   task automatic testReset();
      rd("ctrl", ousr_pkg::ADDR_CTRL, 32'h0000_001c);
      rd("state", ousr_pkg::ADDR_STATE, 32'h0);
      chk("oe", 32'h0, {24'h0, parOe});
      rd("unmapped", 32'h0000_0010, ousr_pkg::BAD_READ);
      chk("slverr", 32'h1, {31'h0, rdErr});
   endtask

   task automatic testShift();
      logic [7:0] pat;
      pat = 8'hb4;
      expState = 8'h00;
      for (int i = 0; i < 8; i++)
         step(2'b01, pat[i], ~pat[i]);
      step(2'b00, 1'b1, 1'b1);
      // clock enable low for six edges must leave every stage as it was
      ceIn <= 1'b0;
      repeat (6) @(posedge clk);
      ceIn <= 1'b1;
      step(2'b00, 1'b0, 1'b0);
      pat = 8'h6d;
      for (int i = 0; i < 8; i++)
         step(2'b10, ~pat[i], pat[i]);
   endtask

   task automatic testOe();
      wr(ousr_pkg::ADDR_CTRL, ctl(2'b00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      @(posedge clk);
      chk("oe on", 32'hff, {24'h0, parOe});
      chk("pins", {24'h0, expState}, {24'h0, pins});
      wr(ousr_pkg::ADDR_CTRL, ctl(2'b00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      @(posedge clk);
      chk("oe a", 32'h0, {24'h0, parOe});
      chk("last", {31'h0, expState[7]}, {31'h0, lastOut});
      wr(ousr_pkg::ADDR_CTRL, ctl(2'b00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      @(posedge clk);
      chk("oe b", 32'h0, {24'h0, parOe});
      wr(ousr_pkg::ADDR_CTRL, ctl(2'b11, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
      @(posedge clk);
      chk("oe load", 32'h0, {24'h0, parOe});
      // fifo full of words captured after reset: no room, valid, oldest word zero
      rd("stat", ousr_pkg::ADDR_STAT, 32'h0000_0016);
      rd("fifo", ousr_pkg::ADDR_FIFO, 32'h0000_0100);
   endtask

   task automatic testLoad();
      logic [7:0] vals [2];
      vals = '{8'h5a, 8'ha3};
      foreach (vals[v])
      begin
         busData <= vals[v];
         wr(ousr_pkg::ADDR_CTRL, ctl(2'b11, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
         repeat (12) @(posedge clk);
         chk("fifo full", 32'h0, {31'h0, loadReady});
         // enough pops to flush words captured before the bus changed
         repeat (6) wr(ousr_pkg::ADDR_CTRL, ctl(2'b11, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
         expState = vals[v];
         rd("loaded", ousr_pkg::ADDR_STATE, {24'h0, expState});
      end
   endtask

   task automatic testClear();
      wr(ousr_pkg::ADDR_CTRL, ctl(2'b01, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
      rd("cleared", ousr_pkg::ADDR_STATE, 32'h0);
      rd("ctrl", ousr_pkg::ADDR_CTRL, ctl(2'b01, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
      chk("first", 32'h0, {31'h0, firstOut});
   endtask

   //------------------------------------------------------------
   // clock, timeout and main sequence
   //------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         errors++;
         results();
      end
   end

   initial
   begin
      sysRst  = 1'b1;
      ceIn    = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 32'h0;
      pwdata  = 32'h0;
      busData = 8'h00;
      repeat (12) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      testReset();
      testShift();
      testOe();
      testLoad();
      testClear();
      results();
   end
endmodule
